// ---- core/accel_pkg.sv ----
package accel_pkg;

    // register map of the serial port
    localparam logic [7:0] OFF_X_MSB    = 8'h01; // x sample, high byte
    localparam logic [7:0] OFF_Y_MSB    = 8'h03; // y sample, high byte
    localparam logic [7:0] OFF_Z_MSB    = 8'h05; // z sample, high byte
    localparam logic [7:0] OFF_OPSTATE  = 8'h0b; // operating_state_reg
    localparam logic [7:0] OFF_EVENT    = 8'h0c; // event_source_status
    localparam logic [7:0] OFF_IDENTITY = 8'h0d; // device_identity
    localparam logic [7:0] OFF_RANGE    = 8'h0e; // sample_range_config
    localparam logic [7:0] OFF_CUTOFF   = 8'h0f; // highpass_cutoff_config
    localparam logic [7:0] OFF_ORIENT   = 8'h10; // orientation_status_reg
    localparam logic [7:0] OFF_FFMT     = 8'h16; // freefall_source_reg
    localparam logic [7:0] OFF_TRANS    = 8'h1e; // transient_source_reg
    localparam logic [7:0] OFF_TAP      = 8'h22; // tap_source_reg

    // field positions
    localparam int EVB_ASLP   = 7; // event byte positions
    localparam int EVB_TRANS  = 5;
    localparam int EVB_ORIENT = 4;
    localparam int EVB_TAP    = 3;
    localparam int EVB_FFMT   = 2;
    localparam int EVB_DRDY   = 0;
    localparam int CUT_BYPASS = 5; // tap_highpass_bypass
    localparam int CUT_LOWPASS = 4; // tap_lowpass_enable

    // reset values and codes
    localparam logic [1:0] RANGE_2G   = 2'h0;
    localparam logic [1:0] RANGE_4G   = 2'h1;
    localparam logic [1:0] RANGE_8G   = 2'h2;
    localparam logic [1:0] RANGE_RSVD = 2'h3;
    localparam logic [1:0] CUT_RESET  = 2'h0;
    localparam logic [1:0] OPS_STANDBY = 2'h0;
    localparam logic [1:0] OPS_WAKE    = 2'h1;
    localparam logic [1:0] OPS_SLEEP   = 2'h2;
    localparam logic [15:0] CUT_BASE_MHZ = 16'h3e80; // 16 Hz in mHz
    localparam logic [6:0] DEV_ADDR    = 7'h2d; // serial address
    localparam logic [7:0] ID_CODE     = 8'h5c; // arbitrary identity

    // timing: inactivity step of the auto-sleep timer
    localparam int STEP_NS         = 640;
    localparam int CLK_NS          = 10;
    localparam int STEP_CYCLES     = STEP_NS / CLK_NS;

    // event carrier, msb first as on the status byte
    typedef struct packed {
        logic aslp;
        logic trans;
        logic orient;
        logic tap;
        logic ffmt;
        logic drdy;
    } event_s;

    // serial engine states
    typedef enum logic [8:0] {
        S_IDLE  = 9'h001,
        S_ADDR  = 9'h002,
        S_AACK  = 9'h004,
        S_REG   = 9'h008,
        S_RACK  = 9'h010,
        S_WDAT  = 9'h020,
        S_WACK  = 9'h040,
        S_RDAT  = 9'h080,
        S_MACK  = 9'h100
    } ser_state_e;

    // operating states
    typedef enum logic [2:0] {
        M_STANDBY = 3'h1,
        M_WAKE    = 3'h2,
        M_SLEEP   = 3'h4
    } op_state_e;

endpackage

// ---- core/pin_sampler.sv ----
`timescale 1ns/1ps
// two-flop synchroniser with edge finding on the settled copy
module pin_sampler (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // pin side
    input  wire logic pin,
    // sampled side
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta;   // first stage, read only by stage two
    logic hold;   // stage two
    logic prev;   // delayed copy for edges

    // idle bus level is high, so reset to one
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta <= 1'b1;
            hold <= 1'b1;
            prev <= 1'b1;
        end else begin
            meta <= pin;
            hold <= meta;
            prev <= hold;
        end
    end

    assign level = hold;
    assign rise  = hold & ~prev;
    assign fall  = ~hold & prev;
endmodule

// ---- core/accel_event_source_and_config.sv ----
`timescale 1ns/1ps
module accel_event_source_and_config (
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    // two-wire serial pins
    input  wire logic                  scl,
    input  wire logic                  sda_in,
    output logic                       sda_out,
    output logic                       sda_oe,
    // detection engines and enables
    input  accel_pkg::event_s          evt_cond,
    input  accel_pkg::event_s          evt_enable,
    // auto-sleep control
    input  wire logic                  active_mode,
    input  wire logic                  autosleep_en,
    input  wire logic [7:0]            inactivity_limit,
    input  accel_pkg::event_s          wake_select,
    input  wire logic [2:0]            wake_rate,
    input  wire logic [2:0]            sleep_rate,
    // configuration out
    output logic [2:0]                 sample_rate,
    output logic [1:0]                 operating_state,
    output logic [3:0]                 full_scale_g,
    output logic                       hpf_out_en,
    output logic                       tap_highpass_bypass,
    output logic                       tap_lowpass_enable,
    output logic [1:0]                 cutoff_select,
    output logic [15:0]                cutoff_mhz,
    output accel_pkg::event_s          event_flags
);
    import accel_pkg::*;

    // sampled pins
    logic scl_lvl, scl_rise, scl_fall;
    logic sda_lvl, sda_rise, sda_fall;

    pin_sampler u_scl (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pin     (scl),
        .level   (scl_lvl),
        .rise    (scl_rise),
        .fall    (scl_fall)
    );

    pin_sampler u_sda (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pin     (sda_in),
        .level   (sda_lvl),
        .rise    (sda_rise),
        .fall    (sda_fall)
    );

    // serial engine state
    ser_state_e  ser;          // protocol phase
    logic [3:0]  bit_cnt;      // bits of the current byte
    logic [7:0]  shreg;        // shift register
    logic [7:0]  ptr;          // register pointer
    logic        rw;           // 1 = read transfer
    logic        nack;         // host refused more data
    logic [7:0]  rd_addr;      // address being loaded
    logic [7:0]  rd_data;      // mux output
    logic        rd_strobe;    // one-cycle read of rd_addr
    logic        wr_strobe;    // one-cycle write of wr_addr
    logic        start_det;    // start or repeated start
    logic        stop_det;     // stop

    // configuration registers
    logic [1:0]  range_select;
    logic [7:0]  cutoff_reg;

    // event logic
    event_s      flags;        // sticky flags
    event_s      gated;        // condition after enable
    event_s      gated_q;      // previous gated value
    event_s      set_vec;      // rising edges
    event_s      clr_vec;      // read-side clears
    logic        aslp_pulse;   // state change of auto-sleep
    logic [2:0]  xyz_seen;     // msb reads since last clear

    // auto-sleep
    op_state_e   mode;
    logic [15:0] pre_cnt;      // step prescaler
    logic [8:0]  idle_steps;   // inactivity in steps

    assign start_det = scl_lvl & sda_fall;
    assign stop_det  = scl_lvl & sda_rise;
    assign sda_out   = 1'b0;   // open drain: only ever pulls low

    // next read address: reloads follow with pointer advance
    assign rd_addr = (ser == S_MACK) ? ptr + 8'h01 : ptr;

    // read mux, unused bits zero
    always_comb begin
        case (rd_addr)
            OFF_OPSTATE:  rd_data = {6'h00, operating_state};
            OFF_EVENT:    rd_data = {flags.aslp, 1'b0, flags.trans,
                                     flags.orient, flags.tap,
                                     flags.ffmt, 1'b0, flags.drdy};
            OFF_IDENTITY: rd_data = ID_CODE;
            OFF_RANGE:    rd_data = {6'h00, range_select};
            OFF_CUTOFF:   rd_data = {2'h0, cutoff_reg[CUT_BYPASS],
                                     cutoff_reg[CUT_LOWPASS], 2'h0,
                                     cutoff_reg[1:0]};
            default:      rd_data = 8'h00;
        endcase
    end

    // serial byte engine, bits taken on scl rise, driven on scl fall
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ser       <= S_IDLE;
            bit_cnt   <= 4'h0;
            shreg     <= 8'h00;
            ptr       <= 8'h00;
            rw        <= 1'b0;
            nack      <= 1'b0;
            sda_oe    <= 1'b0;
            rd_strobe <= 1'b0;
            wr_strobe <= 1'b0;
        end else begin
            rd_strobe <= 1'b0;
            wr_strobe <= 1'b0;
            if (stop_det) begin
                ser    <= S_IDLE;
                sda_oe <= 1'b0;
            end else if (start_det) begin
                ser     <= S_ADDR;
                bit_cnt <= 4'h0;
                sda_oe  <= 1'b0;
            end else if (scl_rise) begin
                // sample host bits
                case (ser)
                    S_ADDR, S_REG, S_WDAT: begin
                        shreg   <= {shreg[6:0], sda_lvl};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    S_RDAT:  bit_cnt <= bit_cnt + 4'h1;
                    S_MACK:  nack <= sda_lvl;
                    default: ;
                endcase
            end else if (scl_fall) begin
                case (ser)
                    S_ADDR: if (bit_cnt == 4'h8) begin
                        if (shreg[7:1] == DEV_ADDR) begin
                            ser    <= S_AACK;
                            rw     <= shreg[0];
                            sda_oe <= 1'b1;
                        end else begin
                            ser <= S_IDLE; // not our address
                        end
                    end
                    S_AACK: begin
                        bit_cnt <= 4'h0;
                        if (rw) begin
                            ser       <= S_RDAT;
                            shreg     <= rd_data;
                            rd_strobe <= 1'b1;
                            sda_oe    <= ~rd_data[7];
                        end else begin
                            ser    <= S_REG;
                            sda_oe <= 1'b0;
                        end
                    end
                    S_REG: if (bit_cnt == 4'h8) begin
                        ptr    <= shreg;
                        ser    <= S_RACK;
                        sda_oe <= 1'b1;
                    end
                    S_RACK, S_WACK: begin
                        ser     <= S_WDAT;
                        bit_cnt <= 4'h0;
                        sda_oe  <= 1'b0;
                    end
                    S_WDAT: if (bit_cnt == 4'h8) begin
                        wr_strobe <= 1'b1;
                        ser       <= S_WACK;
                        sda_oe    <= 1'b1;
                    end
                    S_RDAT: begin
                        if (bit_cnt == 4'h8) begin
                            ser    <= S_MACK;
                            sda_oe <= 1'b0;
                        end else begin
                            sda_oe <= ~shreg[3'h7 - bit_cnt[2:0]];
                        end
                    end
                    S_MACK: begin
                        bit_cnt <= 4'h0;
                        if (nack) begin
                            ser <= S_IDLE;
                        end else begin
                            ser       <= S_RDAT;
                            ptr       <= rd_addr;
                            shreg     <= rd_data;
                            rd_strobe <= 1'b1;
                            sda_oe    <= ~rd_data[7];
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // pointer advances after each written byte
    // (kept separate from the read advance on S_MACK)
    logic [7:0] wr_addr;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_addr <= 8'h00;
        end else if (ser == S_RACK) begin
            wr_addr <= ptr;
        end else if (wr_strobe) begin
            wr_addr <= wr_addr + 8'h01;
        end
    end

    // configuration writes; read-only offsets fall through
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            range_select <= RANGE_2G;
            cutoff_reg   <= {6'h00, CUT_RESET};
        end else if (wr_strobe) begin
            case (wr_addr)
                OFF_RANGE: begin
                    // reserved code is dropped, keeps a legal scale
                    if (shreg[1:0] != RANGE_RSVD) begin
                        range_select <= shreg[1:0];
                    end
                end
                OFF_CUTOFF: cutoff_reg <= shreg & 8'h33;
                default: ;
            endcase
        end
    end

    // range decode in g
    always_comb begin
        case (range_select)
            RANGE_4G: full_scale_g = 4'h4;
            RANGE_8G: full_scale_g = 4'h8;
            default:  full_scale_g = 4'h2;
        endcase
    end

    assign hpf_out_en          = 1'b0;
    assign tap_highpass_bypass = cutoff_reg[CUT_BYPASS];
    assign tap_lowpass_enable  = cutoff_reg[CUT_LOWPASS];
    assign cutoff_select       = cutoff_reg[1:0];

    // normal-mode cutoff: halves per code, then per slower rate from rate 1 up to rate 4
    logic [1:0] rate_shift;
    always_comb begin
        case (sample_rate)
            3'h0, 3'h1: rate_shift = 2'h0;
            3'h2:       rate_shift = 2'h1;
            3'h3:       rate_shift = 2'h2;
            default:    rate_shift = 2'h3;
        endcase
    end
    // three-bit sum: code 3 at the slowest rates shifts by six
    assign cutoff_mhz = CUT_BASE_MHZ >> ({1'b0, cutoff_reg[1:0]}
                                         + {1'b0, rate_shift});

    // read side effects: a source register read clears its flag, drdy needs x, y and z msb reads
    always_comb begin
        clr_vec        = '0;
        clr_vec.aslp   = rd_strobe & (rd_addr == OFF_OPSTATE);
        clr_vec.trans  = rd_strobe & (rd_addr == OFF_TRANS);
        clr_vec.orient = rd_strobe & (rd_addr == OFF_ORIENT);
        clr_vec.tap    = rd_strobe & (rd_addr == OFF_TAP);
        clr_vec.ffmt   = rd_strobe & (rd_addr == OFF_FFMT);
        clr_vec.drdy   = (xyz_seen == 3'h7);
    end

    // note rd_addr equals ptr on the strobe cycle: ptr already moved
    // msb reads of all three axes release the sample flag
    always_ff @(posedge ref_clk) begin
        if (rst || clr_vec.drdy || set_vec.drdy) begin
            xyz_seen <= 3'h0;
        end else if (rd_strobe) begin
            if (rd_addr == OFF_X_MSB) xyz_seen[0] <= 1'b1;
            if (rd_addr == OFF_Y_MSB) xyz_seen[1] <= 1'b1;
            if (rd_addr == OFF_Z_MSB) xyz_seen[2] <= 1'b1;
        end
    end

    // gate each source with its enable, auto-sleep from aslp_pulse
    always_comb begin
        gated      = evt_cond & evt_enable;
        gated.aslp = aslp_pulse & evt_enable.aslp;
    end
    assign set_vec = gated & ~gated_q;

    // sticky flags, set wins over a clear in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_flag
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    flags[gi]   <= 1'b0;
                    gated_q[gi] <= 1'b0;
                end else begin
                    gated_q[gi] <= gated[gi];
                    if (set_vec[gi]) begin
                        flags[gi] <= 1'b1;
                    end else if (clr_vec[gi]) begin
                        flags[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate
    assign event_flags = flags;

    // inactivity prescaler and step counter
    logic any_event;
    assign any_event = |(set_vec & ~event_s'(6'h20));
    always_ff @(posedge ref_clk) begin
        if (rst || mode != M_WAKE || any_event) begin
            pre_cnt    <= 16'h0000;
            idle_steps <= 9'h000;
        end else if (pre_cnt == 16'(STEP_CYCLES - 1)) begin
            pre_cnt <= 16'h0000;
            if (idle_steps[8] == 1'b0) idle_steps <= idle_steps + 9'h001;
        end else begin
            pre_cnt <= pre_cnt + 16'h0001;
        end
    end

    // operating state machine
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode       <= M_STANDBY;
            aslp_pulse <= 1'b0;
        end else begin
            aslp_pulse <= 1'b0;
            case (mode)
                M_STANDBY: if (active_mode) mode <= M_WAKE;
                M_WAKE: begin
                    if (!active_mode) begin
                        mode <= M_STANDBY;
                    end else if (autosleep_en &&
                                 idle_steps > {1'b0, inactivity_limit}) begin
                        mode       <= M_SLEEP;
                        aslp_pulse <= 1'b1;
                    end
                end
                M_SLEEP: begin
                    if (!active_mode) begin
                        mode <= M_STANDBY;
                    end else if (|(set_vec & wake_select)) begin
                        mode       <= M_WAKE;
                        aslp_pulse <= 1'b1;
                    end
                end
                default: mode <= M_STANDBY;
            endcase
        end
    end

    // state code and chosen rate
    always_comb begin
        case (mode)
            M_WAKE:  operating_state = OPS_WAKE;
            M_SLEEP: operating_state = OPS_SLEEP;
            default: operating_state = OPS_STANDBY;
        endcase
        sample_rate = (mode == M_SLEEP) ? sleep_rate : wake_rate;
    end

    // checks
    sequence read_of(logic [7:0] a);
        rd_strobe && rd_addr == a;
    endsequence

    flag_rise_a: assert property (@(posedge ref_clk) disable iff (rst)
        !$past(gated.trans) && gated.trans |=> flags.trans)
        else $error("transient flag missed rising condition");

    trans_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        read_of(OFF_TRANS) ##0 !set_vec.trans |=> !flags.trans)
        else $error("transient flag not cleared by source read");

    aslp_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        read_of(OFF_OPSTATE) ##0 !set_vec.aslp |=> !flags.aslp)
        else $error("autosleep flag not cleared");

    gate_off_a: assert property (@(posedge ref_clk) disable iff (rst)
        !evt_enable.tap && !flags.tap |=> !flags.tap)
        else $error("disabled tap source set its flag");

    drdy_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
        flags.drdy && xyz_seen != 3'h7 |=> flags.drdy)
        else $error("sample flag cleared without xyz reads");

    sleep_entry_a: assert property (@(posedge ref_clk) disable iff (rst)
        mode == M_WAKE && active_mode && autosleep_en &&
        idle_steps > {1'b0, inactivity_limit}
        |=> mode == M_SLEEP && aslp_pulse
            ##1 (flags.aslp || !evt_enable.aslp))
        else $error("no sleep after inactivity limit");

    wake_entry_a: assert property (@(posedge ref_clk) disable iff (rst)
        mode == M_SLEEP && active_mode && |(set_vec & wake_select)
        |=> mode == M_WAKE && sample_rate == wake_rate)
        else $error("no wake on selected event");

    range_rsvd_a: assert property (@(posedge ref_clk) disable iff (rst)
        range_select != RANGE_RSVD)
        else $error("reserved range stored");

    hpf_off_a: assert property (@(posedge ref_clk) disable iff (rst)
        !hpf_out_en)
        else $error("output high-pass enabled");

    ro_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        wr_strobe && wr_addr != OFF_RANGE && wr_addr != OFF_CUTOFF
        |=> $stable(range_select) && $stable(cutoff_reg))
        else $error("write to read-only offset changed state");
endmodule

// ---- bench/host_model.sv ----
`timescale 1ns/1ps
// two-wire host: owns the clock, only ever pulls data low
module host_model (
    // bus side
    input  wire logic sda,
    output logic      scl,
    output logic      pull
);
    // idle bus, clock parked high
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end
    // one bit: data set in low phase, sampled mid high phase
    task automatic clk_bit(input logic b, output logic s);
        pull = ~b;
        #31.25 scl = 1'b1;
        #31.25 s = sda;
        #31.25 scl = 1'b0;
        #31.25;
    endtask
    // start or repeated start; long low phase lets device ack end
    task automatic start();
        pull = 1'b0;
        #62.5 scl = 1'b1;
        #31.25 pull = 1'b1;
        #31.25 scl = 1'b0;
        #31.25;
    endtask
    // stop: data rises while clock high
    task automatic stop();
        pull = 1'b1;
        #31.25 scl = 1'b1;
        #31.25 pull = 1'b0;
        #62.5;
    endtask
    // byte out msb first, ack slot released
    task automatic tx(input logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
        clk_bit(1'b1, s);
    endtask
    // byte in; nack on the last byte ends the read
    task automatic rx(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, s);
            d[i] = s;
        end
        clk_bit(last, s);
    endtask
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
    import accel_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, act = 1'b0, asl = 1'b0;
    logic [5:0] evc = '0, ena = 6'h3f, wsel = '0; // event vectors
    logic scl, pull, sda_out, sda_oe, hpf, byp, lpf;
    logic [2:0] srate;
    logic [1:0] ostate, csel;
    logic [3:0] fsg;
    logic [15:0] cmhz;
    event_s flags;
    logic [7:0] d;
    int num_errors = 0, samples_checked = 0;
    wire sda = ~(pull | sda_oe); // pull-up wins unless pulled
    always #5 ref_clk = ~ref_clk;
    host_model i_host (.sda(sda), .scl(scl), .pull(pull));
    accel_event_source_and_config i_dut (.ref_clk(ref_clk), .rst(rst),
        .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .evt_cond(evc), .evt_enable(ena), .active_mode(act),
        .autosleep_en(asl), .inactivity_limit(8'h02), .wake_select(wsel),
        .wake_rate(3'h1), .sleep_rate(3'h6), .sample_rate(srate),
        .operating_state(ostate), .full_scale_g(fsg), .hpf_out_en(hpf),
        .tap_highpass_bypass(byp), .tap_lowpass_enable(lpf),
        .cutoff_select(csel), .cutoff_mhz(cmhz), .event_flags(flags));
    // verdict and end of run
    task automatic give_verdict();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one comparison
    task automatic chk(input string n, input logic [15:0] e, g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, v);
        i_host.start();
        i_host.tx({DEV_ADDR, 1'b0});
        i_host.tx(a);
        i_host.tx(v);
        i_host.stop();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        i_host.start();
        i_host.tx({DEV_ADDR, 1'b0});
        i_host.tx(a);
        i_host.start();
        i_host.tx({DEV_ADDR, 1'b1});
        i_host.rx(1'b1, v);
        i_host.stop();
    endtask
    // bounded wait on the operating state
    task automatic wait_state(input logic [1:0] s);
        int n = 0;
        while (ostate !== s && n < 2000) begin
            @(negedge ref_clk);
            n++;
        end
        chk("state", s, ostate);
        if (n >= 2000) give_verdict();
    endtask
    // hang guard
    initial begin
        #600000;
        num_errors++;
        give_verdict();
    end
    initial begin
        logic [7:0] offs [4] = '{OFF_TRANS, OFF_ORIENT, OFF_TAP, OFF_FFMT};
        repeat (4) @(negedge ref_clk);
        rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk("flags", 0, flags);
        chk("hpf", 0, hpf);
        wr(OFF_IDENTITY, 8'h00);
        rd(OFF_IDENTITY, d);
        chk("ident", ID_CODE, d);
        chk("sda", 0, {sda_out, sda_oe});
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            wr(OFF_RANGE, 8'(i));
            rd(OFF_RANGE, d);
            chk("range", (i == 3) ? 16'h2 : 16'(i), d);
            chk("scale", (i == 3) ? 16'h8 : 16'(2 << i), fsg);
            wr(OFF_CUTOFF, 8'hcc | 8'(i));
            rd(OFF_CUTOFF, d);
            chk("cutreg", 16'(i), d);
            chk("cutmhz", 16'(16000 >> i), cmhz);
            chk("csel", 16'(i), csel);
        end
        wr(OFF_CUTOFF, 8'hff);
        chk("tapbits", 2'h3, {byp, lpf});
        wr(OFF_EVENT, 8'hff);
        rd(OFF_EVENT, d);
        chk("evt", 0, d);
        $display("test config done");
        for (int i = 0; i < 4; i++) begin
            @(negedge ref_clk) evc[4 - i] = 1'b1;
            rd(OFF_EVENT, d);
            chk("evt", 16'(8'h20 >> i), d);
            rd(offs[i], d);
            rd(OFF_EVENT, d);
            chk("evt", 0, d);
            @(negedge ref_clk) evc = '0;
        end
        ena = 6'h3b;
        @(negedge ref_clk) evc[2] = 1'b1;
        rd(OFF_EVENT, d);
        chk("evt", 0, d);
        @(negedge ref_clk) evc = 6'h01;
        ena = 6'h3f;
        rd(OFF_EVENT, d);
        chk("evt", 8'h01, d);
        rd(OFF_X_MSB, d);
        rd(OFF_Y_MSB, d);
        rd(OFF_EVENT, d);
        chk("evt", 8'h01, d);
        rd(OFF_Z_MSB, d);
        rd(OFF_EVENT, d);
        chk("evt", 0, d);
        $display("test events done");
        @(negedge ref_clk) evc = '0;
        {act, asl} = 2'h3;
        wait_state(OPS_SLEEP);
        chk("rate", 3'h6, srate);
        chk("cutmhz", 16'h00fa, cmhz);
        rd(OFF_EVENT, d);
        chk("evt", 8'h80, d);
        rd(OFF_OPSTATE, d);
        chk("opstate", OPS_SLEEP, d);
        rd(OFF_EVENT, d);
        chk("evt", 0, d);
        @(negedge ref_clk) wsel = 6'h04;
        evc[2] = 1'b1;
        wait_state(OPS_WAKE);
        chk("rate", 3'h1, srate);
        $display("test sleep done");
        give_verdict();
    end
endmodule
